// File: hdl/erxd_pkg.sv
// shared constants and types of the receive descriptor dma engine
package erxd_pkg;
  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_POLL = 8'h04;
  localparam logic [7:0] A_BASE = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_IEN = 8'h10;
  localparam logic [7:0] A_WDOG = 8'h14;
  localparam logic [7:0] A_MISS = 8'h18;
  localparam logic [7:0] A_FILT = 8'h1C;
  localparam logic [7:0] A_CUR = 8'h20;
  // control and filter bit positions
  localparam int CTRL_START = 1;
  localparam int CTRL_TS_EN = 2;
  localparam int CTRL_FLUSH_DIS = 24;
  localparam int FILT_RX_ALL = 31;
  // status bit positions
  localparam int ST_RI = 6;
  localparam int ST_RBU = 7;
  localparam int ST_AIS = 15;
  localparam int ST_NIS = 16;
  localparam int ST_MAC_LINE = 26;
  localparam int ST_MAC_MMC = 27;
  localparam int ST_MAC_PMT = 28;
  localparam logic [31:0] NORM_MASK = 32'h1C00_0040;
  localparam logic [31:0] ABN_MASK = 32'h0000_0080;
  // descriptor layout
  localparam int D_OWN = 31;
  localparam int D_ERR = 14;
  localparam int D_FS = 9;
  localparam int D_LS = 8;
  localparam int D1_NO_IRQ = 31;
  localparam int D1_SIZE_MSB = 12;
  localparam logic [31:0] OFF_W6 = 32'h0000_0018;
  localparam logic [31:0] OFF_W7 = 32'h0000_001C;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] IEN_RST = 32'h0000_0000;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  // watchdog unit: one count is this value plus one aclk cycles (25.6 us at 10 MHz)
  localparam logic [7:0] WDOG_UNIT_LAST = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } erxd_memreq_t;

  typedef struct packed {
    logic [31:0] data;
    logic sof;
    logic eof;
    logic pass;
  } erxd_beat_t;

  typedef struct packed {
    logic [31:0] word;
    logic ts_ok;
    logic [63:0] ts;
  } erxd_rxstat_t;

  typedef enum logic [4:0] {
    S_STOP, S_FETCH, S_MEMR, S_DECIDE, S_IDLE, S_TAKE, S_MEMW, S_AFTW,
    S_STWAIT, S_TS7, S_W0, S_FINI, S_SUSPIN, S_SUSP, S_GAP
  } erxd_state_t;

  typedef enum logic [2:0] {
    W_START, W_POLL, W_SUSP, W_FULL, W_DONE
  } erxd_why_t;
endpackage

// File: hdl/erxd_dma.sv
// receive descriptor dma engine with axi4-lite registers
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ns
module erxd_dma (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host memory master port
  output erxd_pkg::erxd_memreq_t mem_req,
  output logic mem_valid,
  input wire logic mem_ready,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  // receive fifo layer
  input wire erxd_pkg::erxd_beat_t fifo_beat,
  input wire logic fifo_valid,
  output logic fifo_ready,
  output logic fifo_flush,
  output logic fifo_drop,
  input wire erxd_pkg::erxd_rxstat_t fifo_stat,
  input wire logic fifo_stat_valid,
  output logic fifo_stat_ack,
  // mac core event pulses and interrupt
  input wire logic mac_line_evt,
  input wire logic mac_mmc_evt,
  input wire logic mac_pmt_evt,
  output logic dma_irq_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // descriptor word 0 as written back: owner always handed to the host
  function automatic logic [31:0] close_w0(input logic [31:0] stat,
      input logic fs, input logic ls, input logic err);
    logic [31:0] r;
    r = stat;
    r[erxd_pkg::D_OWN] = 1'b0;
    r[erxd_pkg::D_FS] = fs;
    r[erxd_pkg::D_LS] = ls;
    r[erxd_pkg::D_ERR] = stat[erxd_pkg::D_ERR] | err;
    return r;
  endfunction

  // ---------------- axi4-lite slave ----------------
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;
  logic [31:0] ctrl_q, base_q, ien_q, filt_q, st_q, cur_addr_q;
  logic [7:0] wdog_q;
  logic [15:0] miss_q;
  logic poll_q;
  logic nis, ais;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_ok = aw_addr_q inside {erxd_pkg::A_CTRL, erxd_pkg::A_POLL,
      erxd_pkg::A_BASE, erxd_pkg::A_STAT, erxd_pkg::A_IEN,
      erxd_pkg::A_WDOG, erxd_pkg::A_FILT};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= erxd_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? erxd_pkg::RESP_OKAY : erxd_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr[7:0])
      erxd_pkg::A_CTRL: rd_word = ctrl_q;
      erxd_pkg::A_POLL: rd_word = 32'h0000_0000;
      erxd_pkg::A_BASE: rd_word = base_q;
      erxd_pkg::A_STAT: rd_word = st_q | {15'h0000, nis, ais, 15'h0000};
      erxd_pkg::A_IEN: rd_word = ien_q;
      erxd_pkg::A_WDOG: rd_word = {24'h00_0000, wdog_q};
      erxd_pkg::A_MISS: rd_word = {16'h0000, miss_q};
      erxd_pkg::A_FILT: rd_word = filt_q;
      erxd_pkg::A_CUR: rd_word = cur_addr_q;
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= erxd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? erxd_pkg::RESP_OKAY : erxd_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // software-written configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= erxd_pkg::CTRL_RST;
      base_q <= erxd_pkg::BASE_RST;
      ien_q <= erxd_pkg::IEN_RST;
      filt_q <= 32'h0000_0000;
      wdog_q <= 8'h00;
      poll_q <= 1'b0;
    end else begin
      poll_q <= wr_fire && aw_addr_q == erxd_pkg::A_POLL;
      if (wr_fire) begin
        unique case (aw_addr_q)
          erxd_pkg::A_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
          erxd_pkg::A_BASE: base_q <= merge(base_q, w_data_q, w_strb_q);
          erxd_pkg::A_IEN: ien_q <= merge(ien_q, w_data_q, w_strb_q);
          erxd_pkg::A_FILT: filt_q <= merge(filt_q, w_data_q, w_strb_q);
          erxd_pkg::A_WDOG: if (w_strb_q[0]) wdog_q <= w_data_q[7:0];
          default: ;
        endcase
      end
    end
  end

  logic start_en, ts_en, flush_dis, rx_all;
  assign start_en = ctrl_q[erxd_pkg::CTRL_START];
  assign ts_en = ctrl_q[erxd_pkg::CTRL_TS_EN];
  assign flush_dis = ctrl_q[erxd_pkg::CTRL_FLUSH_DIS];
  assign rx_all = filt_q[erxd_pkg::FILT_RX_ALL];

  // ---------------- receive engine ----------------
  erxd_pkg::erxd_state_t state_q, ret_q;
  erxd_pkg::erxd_why_t why_q;
  logic [1:0] idx_q;
  logic [31:0] f_addr_q, f_w1_q, f_w2_q, f_w3_q;
  logic f_own_q;
  logic [31:0] cur_w1_q, cur_w2_q, cur_w3_q;
  logic [13:0] cnt_q;
  logic first_q, eof_q;
  logic ri_set_q, rbu_set_q, wdt_start_q, miss_inc_q;
  logic buf_full;

  assign buf_full = ({1'b0, cnt_q} + 15'h0004) >=
      {2'b00, cur_w1_q[erxd_pkg::D1_SIZE_MSB:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= erxd_pkg::S_STOP;
      ret_q <= erxd_pkg::S_STOP;
      why_q <= erxd_pkg::W_START;
      idx_q <= 2'h0;
      f_addr_q <= 32'h0000_0000;
      f_w1_q <= 32'h0000_0000;
      f_w2_q <= 32'h0000_0000;
      f_w3_q <= 32'h0000_0000;
      f_own_q <= 1'b0;
      cur_addr_q <= 32'h0000_0000;
      cur_w1_q <= 32'h0000_0000;
      cur_w2_q <= 32'h0000_0000;
      cur_w3_q <= 32'h0000_0000;
      cnt_q <= 14'h0000;
      first_q <= 1'b0;
      eof_q <= 1'b0;
      mem_req <= '0;
      mem_valid <= 1'b0;
      fifo_ready <= 1'b0;
      fifo_flush <= 1'b0;
      fifo_drop <= 1'b0;
      fifo_stat_ack <= 1'b0;
      ri_set_q <= 1'b0;
      rbu_set_q <= 1'b0;
      wdt_start_q <= 1'b0;
      miss_inc_q <= 1'b0;
    end else begin
      fifo_flush <= 1'b0;
      fifo_drop <= 1'b0;
      fifo_stat_ack <= 1'b0;
      ri_set_q <= 1'b0;
      rbu_set_q <= 1'b0;
      wdt_start_q <= 1'b0;
      miss_inc_q <= 1'b0;
      unique case (state_q)
        erxd_pkg::S_STOP: if (start_en) begin
          f_addr_q <= base_q;
          why_q <= erxd_pkg::W_START;
          idx_q <= 2'h0;
          state_q <= erxd_pkg::S_FETCH;
        end
        erxd_pkg::S_FETCH: begin
          mem_valid <= 1'b1;
          mem_req <= '{we: 1'b0, addr: f_addr_q + {28'h000_0000, idx_q, 2'h0},
              wdata: 32'h0000_0000};
          state_q <= erxd_pkg::S_MEMR;
        end
        erxd_pkg::S_MEMR: begin
          if (mem_valid && mem_ready) mem_valid <= 1'b0;
          if (mem_rvalid) begin
            unique case (idx_q)
              2'h0: f_own_q <= mem_rdata[erxd_pkg::D_OWN];
              2'h1: f_w1_q <= mem_rdata;
              2'h2: f_w2_q <= mem_rdata;
              2'h3: f_w3_q <= mem_rdata;
            endcase
            idx_q <= idx_q + 2'h1;
            state_q <= idx_q == 2'h3 ? erxd_pkg::S_DECIDE :
                erxd_pkg::S_FETCH;
          end
        end
        erxd_pkg::S_DECIDE: begin
          cur_addr_q <= f_addr_q;
          if (f_own_q) begin
            cur_w1_q <= f_w1_q;
            cur_w2_q <= f_w2_q;
            cur_w3_q <= f_w3_q;
          end
          unique case (why_q)
            erxd_pkg::W_FULL: begin
              // closing the old descriptor: its address is still cur_addr_q
              mem_valid <= 1'b1;
              mem_req <= '{we: 1'b1, addr: cur_addr_q, wdata: close_w0(
                  32'h0000_0000, first_q, !f_own_q && !flush_dis,
                  !f_own_q && !flush_dis)};
              first_q <= 1'b0;
              cnt_q <= 14'h0000;
              ret_q <= f_own_q ? erxd_pkg::S_TAKE : erxd_pkg::S_SUSPIN;
              state_q <= erxd_pkg::S_MEMW;
            end
            erxd_pkg::W_SUSP: if (f_own_q) begin
              state_q <= erxd_pkg::S_IDLE;
            end else if (flush_dis) begin
              rbu_set_q <= 1'b1;
              state_q <= erxd_pkg::S_SUSP;
            end else begin
              fifo_drop <= 1'b1;
              miss_inc_q <= 1'b1;
              ret_q <= erxd_pkg::S_SUSP;
              state_q <= erxd_pkg::S_GAP;
            end
            default: state_q <= f_own_q ? erxd_pkg::S_IDLE :
                erxd_pkg::S_SUSPIN;
          endcase
        end
        erxd_pkg::S_IDLE: if (!start_en) begin
          state_q <= erxd_pkg::S_STOP;
        end else if (fifo_valid && fifo_beat.sof) begin
          // the fifo layer raises sof only past its threshold or when whole
          if (!fifo_beat.pass && !rx_all) begin
            fifo_drop <= 1'b1;
            ret_q <= erxd_pkg::S_IDLE;
            state_q <= erxd_pkg::S_GAP;
          end else begin
            first_q <= 1'b1;
            cnt_q <= 14'h0000;
            fifo_ready <= 1'b1;
            state_q <= erxd_pkg::S_TAKE;
          end
        end
        erxd_pkg::S_TAKE: if (fifo_valid && fifo_ready) begin
          fifo_ready <= 1'b0;
          eof_q <= fifo_beat.eof;
          mem_valid <= 1'b1;
          mem_req <= '{we: 1'b1, addr: cur_w2_q + {18'h0_0000, cnt_q},
              wdata: fifo_beat.data};
          ret_q <= erxd_pkg::S_AFTW;
          state_q <= erxd_pkg::S_MEMW;
        end
        erxd_pkg::S_MEMW: if (mem_ready) begin
          mem_valid <= 1'b0;
          // ready only after the close write, so no beat lands unseen
          fifo_ready <= ret_q == erxd_pkg::S_TAKE;
          state_q <= ret_q;
        end
        erxd_pkg::S_AFTW: begin
          cnt_q <= cnt_q + 14'h0004;
          if (eof_q) begin
            state_q <= erxd_pkg::S_STWAIT;
          end else if (buf_full) begin
            f_addr_q <= cur_w3_q;
            why_q <= erxd_pkg::W_FULL;
            idx_q <= 2'h0;
            state_q <= erxd_pkg::S_FETCH;
          end else begin
            fifo_ready <= 1'b1;
            state_q <= erxd_pkg::S_TAKE;
          end
        end
        erxd_pkg::S_STWAIT: if (fifo_stat_valid) begin
          if (ts_en) begin
            mem_valid <= 1'b1;
            mem_req <= '{we: 1'b1, addr: cur_addr_q + erxd_pkg::OFF_W6,
                wdata: fifo_stat.ts_ok ? fifo_stat.ts[31:0] :
                32'hFFFF_FFFF};
            ret_q <= erxd_pkg::S_TS7;
            state_q <= erxd_pkg::S_MEMW;
          end else begin
            state_q <= erxd_pkg::S_W0;
          end
        end
        erxd_pkg::S_TS7: begin
          mem_valid <= 1'b1;
          mem_req <= '{we: 1'b1, addr: cur_addr_q + erxd_pkg::OFF_W7,
              wdata: fifo_stat.ts_ok ? fifo_stat.ts[63:32] :
              32'hFFFF_FFFF};
          ret_q <= erxd_pkg::S_W0;
          state_q <= erxd_pkg::S_MEMW;
        end
        erxd_pkg::S_W0: begin
          fifo_stat_ack <= 1'b1;
          mem_valid <= 1'b1;
          mem_req <= '{we: 1'b1, addr: cur_addr_q, wdata: close_w0(
              fifo_stat.word, first_q, 1'b1, 1'b0)};
          ret_q <= erxd_pkg::S_FINI;
          state_q <= erxd_pkg::S_MEMW;
        end
        erxd_pkg::S_FINI: begin
          ri_set_q <= !cur_w1_q[erxd_pkg::D1_NO_IRQ];
          wdt_start_q <= cur_w1_q[erxd_pkg::D1_NO_IRQ];
          f_addr_q <= cur_w3_q;
          why_q <= erxd_pkg::W_DONE;
          idx_q <= 2'h0;
          state_q <= erxd_pkg::S_FETCH;
        end
        erxd_pkg::S_SUSPIN: begin
          rbu_set_q <= 1'b1;
          fifo_flush <= !flush_dis;
          state_q <= erxd_pkg::S_SUSP;
        end
        erxd_pkg::S_SUSP: if (!start_en) begin
          state_q <= erxd_pkg::S_STOP;
        end else if (poll_q || (fifo_valid && fifo_beat.sof)) begin
          // refetch the retained host-owned descriptor
          f_addr_q <= cur_addr_q;
          why_q <= poll_q ? erxd_pkg::W_POLL : erxd_pkg::W_SUSP;
          idx_q <= 2'h0;
          state_q <= erxd_pkg::S_FETCH;
        end
        // one spare cycle lets the fifo retire a dropped frame
        erxd_pkg::S_GAP: state_q <= ret_q;
        default: state_q <= erxd_pkg::S_STOP;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) miss_q <= 16'h0000;
    else if (miss_inc_q) miss_q <= miss_q + 16'h0001;
  end

  // ---------------- receive interrupt watchdog ----------------
  logic [7:0] pre_q, wdt_cnt_q;
  logic wdt_run_q, wdt_fire_q, tick;
  assign tick = pre_q == erxd_pkg::WDOG_UNIT_LAST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 8'h00;
      wdt_cnt_q <= 8'h00;
      wdt_run_q <= 1'b0;
      wdt_fire_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 8'h01;
      wdt_fire_q <= 1'b0;
      if (ri_set_q) begin
        wdt_run_q <= 1'b0;
      end else if (wdt_start_q && wdog_q != 8'h00) begin
        wdt_run_q <= 1'b1;
        wdt_cnt_q <= wdog_q;
      end else if (wdt_run_q && tick) begin
        wdt_cnt_q <= wdt_cnt_q - 8'h01;
        if (wdt_cnt_q == 8'h01) begin
          wdt_run_q <= 1'b0;
          wdt_fire_q <= 1'b1;
        end
      end
    end
  end

  // ---------------- status and interrupt ----------------
  logic [31:0] st_set, st_clr;
  always_comb begin
    st_set = 32'h0000_0000;
    st_set[erxd_pkg::ST_RI] = ri_set_q || wdt_fire_q;
    st_set[erxd_pkg::ST_RBU] = rbu_set_q;
    st_set[erxd_pkg::ST_MAC_LINE] = mac_line_evt;
    st_set[erxd_pkg::ST_MAC_MMC] = mac_mmc_evt;
    st_set[erxd_pkg::ST_MAC_PMT] = mac_pmt_evt;
    st_clr = (wr_fire && aw_addr_q == erxd_pkg::A_STAT) ?
        merge(32'h0000_0000, w_data_q, w_strb_q) : 32'h0000_0000;
  end

  assign nis = |(st_q & ien_q & erxd_pkg::NORM_MASK);
  assign ais = |(st_q & ien_q & erxd_pkg::ABN_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= 32'h0000_0000;
      dma_irq_out <= 1'b0;
    end else begin
      // a new event wins over a clear in the same cycle
      st_q <= ((st_q & ~st_clr) | st_set) &
          (erxd_pkg::NORM_MASK | erxd_pkg::ABN_MASK);
      dma_irq_out <= nis || ais;
    end
  end

  // ---------------- checks ----------------
  chk_start_fetch: assert property (
    state_q == erxd_pkg::S_STOP && start_en |=> state_q == erxd_pkg::S_FETCH)
    else $error("start did not begin a descriptor fetch");
  chk_close_final: assert property (
    state_q == erxd_pkg::S_W0 |=> mem_valid && mem_req.we &&
      !mem_req.wdata[erxd_pkg::D_OWN] && mem_req.wdata[erxd_pkg::D_LS])
    else $error("final close did not clear owner and set last");
  chk_ack_order: assert property (
    fifo_stat_ack |-> mem_valid && mem_req.addr == cur_addr_q &&
      $past(state_q) == erxd_pkg::S_W0)
    else $error("status acknowledged outside word 0 write-back");
  chk_stamp_ones: assert property (
    state_q == erxd_pkg::S_STWAIT && fifo_stat_valid && ts_en &&
      !fifo_stat.ts_ok |=> mem_req.wdata == 32'hFFFF_FFFF)
    else $error("missing stamp not written as all ones");
  chk_flush_gate: assert property (
    fifo_flush |-> !$past(flush_dis) &&
      $past(state_q) == erxd_pkg::S_SUSPIN)
    else $error("flush with flush disable set");
  chk_ri_sets: assert property (
    ri_set_q |=> st_q[erxd_pkg::ST_RI])
    else $error("receive irq flag not set after frame close");
  chk_w1c_hold: assert property (
    st_q[erxd_pkg::ST_RBU] && !st_clr[erxd_pkg::ST_RBU] |=>
      st_q[erxd_pkg::ST_RBU])
    else $error("status bit cleared without a write of one");
  chk_irq_masked: assert property (
    !(|(st_q & ien_q)) |=> !dma_irq_out)
    else $error("irq raised with no enabled status bit");
  chk_miss_count: assert property (
    miss_inc_q |=> miss_q == $past(miss_q) + 16'h0001)
    else $error("missed frame counter did not advance");
  chk_mac_flag: assert property (
    mac_line_evt |=> st_q[erxd_pkg::ST_MAC_LINE])
    else $error("mac line event did not set its flag");
endmodule // erxd_dma

// File: sim/erxd_host_mem.sv
// host memory model behind the dma master port
`timescale 1ns/1ns
module erxd_host_mem (
  // clock
  input wire logic aclk,
  // dma master port
  input wire erxd_pkg::erxd_memreq_t mem_req,
  input wire logic mem_valid,
  output logic mem_ready,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:63];
  logic slow_q = 1'b0;
  initial mem_rvalid = 1'b0;
  initial mem_rdata = 32'h0;
  // ready on alternate cycles: requests meet both prompt and late answers
  assign mem_ready = slow_q;
  always @(posedge aclk) begin
    slow_q <= ~slow_q;
    mem_rvalid <= mem_valid && mem_ready && !mem_req.we;
    // idle data toggles so a stale word never passes for an answer
    mem_rdata <= ~mem_rdata;
    if (mem_valid && mem_ready && mem_req.we)
      mem[mem_req.addr[7:2]] <= mem_req.wdata;
    if (mem_valid && mem_ready && !mem_req.we)
      mem_rdata <= mem[mem_req.addr[7:2]];
  end
endmodule // erxd_host_mem

// File: sim/ethernet_rx_descriptor_dma_tb_top.sv
// testbench of the receive descriptor dma engine
`timescale 1ns/1ns
module ethernet_rx_descriptor_dma_tb_top;
  logic aclk, aresetn, mem_valid, mem_ready, mem_rvalid, dma_irq_out;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, fifo_valid, fifo_ready, fifo_flush;
  logic fifo_drop, fifo_stat_valid, fifo_stat_ack;
  logic mac_line_evt, mac_mmc_evt, mac_pmt_evt;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [31:0] mem_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int failures = 0, tests_run = 0, cyc = 0, flushes = 0;
  erxd_pkg::erxd_memreq_t mem_req;
  erxd_pkg::erxd_beat_t fifo_beat;
  erxd_pkg::erxd_rxstat_t fifo_stat;
  erxd_dma erxd_dma_i (.*);
  erxd_host_mem erxd_host_mem_i (.*);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  // a hang anywhere ends here; the full run needs well under 4000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up;
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rr = s_axi_bresp;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  // one-beat frame, then its status held until the engine acknowledges
  task send(input logic [31:0] d, input logic [31:0] s);
    fifo_beat <= '{d, 1'b1, 1'b1, 1'b1};
    fifo_valid <= 1'b1;
    do @(posedge aclk); while (!fifo_ready);
    fifo_valid <= 1'b0;
    fifo_stat <= '{s, 1'b0, 64'h0};
    fifo_stat_valid <= 1'b1;
    do @(posedge aclk); while (!fifo_stat_ack);
    fifo_stat_valid <= 1'b0;
  endtask
  always @(posedge aclk) begin
    if (fifo_flush === 1'b1) flushes <= flushes + 1;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, fifo_valid, fifo_stat_valid} = 4'h0;
    {mac_line_evt, mac_mmc_evt, mac_pmt_evt} = 3'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    fifo_beat = '0;
    fifo_stat = '0;
    erxd_host_mem_i.mem[0] = 32'h8000_0000;
    erxd_host_mem_i.mem[1] = 32'h0000_0040;
    erxd_host_mem_i.mem[2] = 32'h0000_0080;
    erxd_host_mem_i.mem[3] = 32'h0000_0020;
    erxd_host_mem_i.mem[6] = 32'hA5A5_A5A5;
    erxd_host_mem_i.mem[8] = 32'h0000_0000;
    erxd_host_mem_i.mem[9] = 32'h8000_0040;
    erxd_host_mem_i.mem[10] = 32'h0000_0060;
    erxd_host_mem_i.mem[11] = 32'h0000_0040;
    erxd_host_mem_i.mem[16] = 32'h0000_0000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(erxd_pkg::A_STAT);
    chk(rd, 32'h0);
    rdr(8'h40);
    chk({30'h0, rr}, {30'h0, erxd_pkg::RESP_SLVERR});
    wr(erxd_pkg::A_BASE, 32'h0);
    wr(erxd_pkg::A_CTRL, 32'h0000_0002);
    send(32'h1234_5678, 32'h0000_0020);
    repeat (30) begin
      rdr(erxd_pkg::A_STAT);
      if (rd[7] === 1'b1) break;
    end
    chk(rd, 32'h0000_00C0);
    chk(erxd_host_mem_i.mem[32], 32'h1234_5678);
    chk(erxd_host_mem_i.mem[0], 32'h0000_0320);
    chk(erxd_host_mem_i.mem[6], 32'hA5A5_A5A5);
    wr(erxd_pkg::A_IEN, 32'h0000_0040);
    rdr(erxd_pkg::A_STAT);
    chk(rd, 32'h0001_00C0);
    chk({31'h0, dma_irq_out}, 32'h1);
    wr(erxd_pkg::A_STAT, 32'h0000_0040);
    rdr(erxd_pkg::A_STAT);
    chk(rd, 32'h0000_0080);
    chk({31'h0, dma_irq_out}, 32'h0);
    mac_line_evt <= 1'b1;
    @(posedge aclk);
    mac_line_evt <= 1'b0;
    rdr(erxd_pkg::A_STAT);
    chk(rd, 32'h0400_0080);
    wr(erxd_pkg::A_STAT, 32'h0400_0080);
    wr(erxd_pkg::A_MISS, 32'h0000_0001);
    chk({30'h0, rr}, {30'h0, erxd_pkg::RESP_SLVERR});
    erxd_host_mem_i.mem[8] = 32'h8000_0000;
    wr(erxd_pkg::A_WDOG, 32'h0000_0002);
    wr(erxd_pkg::A_CTRL, 32'h0000_0006);
    wr(erxd_pkg::A_POLL, 32'h0000_0000);
    send(32'hCAFE_0001, 32'h8000_0050);
    repeat (30) begin
      rdr(erxd_pkg::A_STAT);
      if (rd[7] === 1'b1) break;
    end
    chk(rd, 32'h0000_0080);
    chk(erxd_host_mem_i.mem[24], 32'hCAFE_0001);
    chk(erxd_host_mem_i.mem[14], 32'hFFFF_FFFF);
    chk(erxd_host_mem_i.mem[15], 32'hFFFF_FFFF);
    chk(erxd_host_mem_i.mem[8], 32'h0000_0350);
    repeat (3 * (int'(erxd_pkg::WDOG_UNIT_LAST) + 1)) @(posedge aclk);
    rdr(erxd_pkg::A_STAT);
    chk(rd, 32'h0001_00C0);
    fifo_beat <= '{32'h0, 1'b1, 1'b1, 1'b1};
    fifo_valid <= 1'b1;
    do @(posedge aclk); while (!fifo_drop);
    fifo_valid <= 1'b0;
    rdr(erxd_pkg::A_MISS);
    chk(rd, 32'h0000_0001);
    chk(flushes, 32'h0000_0002);
    wrap_up;
  end
endmodule // ethernet_rx_descriptor_dma_tb_top
